/* File: logic/drive_sup_pkg.sv */
package drive_sup_pkg;

  localparam int VW      = 12;
  localparam int CW      = 16;
  localparam int GPIO_N  = 4;
  localparam int ENC_N   = 6;
  localparam int HALL_N  = 3;
  localparam int PHASE_N = 3;
  localparam int PWM_W   = 8;
  localparam int DUR_W   = 16;
  localparam int TICK_W  = 16;
  localparam int PIN_N   = GPIO_N + ENC_N + HALL_N + 1;

  // dump duration counts in units of this tick
  localparam int CLK_PERIOD_NS          = 25;
  localparam int DUMP_TICK_NS           = 1_000_000;
  localparam int DUMP_TICK_CYCLES_DEF   = DUMP_TICK_NS / CLK_PERIOD_NS;

  localparam logic [1:0] EV_ENABLED = 2'h0;
  localparam logic [1:0] EV_FAULT   = 2'h1;
  localparam logic [1:0] EV_BRAKE   = 2'h2;
  localparam logic [1:0] EV_DUMP    = 2'h3;

  typedef enum logic [1:0] {
    CMD_CURRENT  = 2'h0,
    CMD_VELOCITY = 2'h1,
    CMD_POSITION = 2'h2
  } cmd_mode_t;

  typedef enum logic [5:0] {
    S_LOAD      = 6'h01,
    S_PRECHARGE = 6'h02,
    S_READY     = 6'h04,
    S_ENABLED   = 6'h08,
    S_FAULTED   = 6'h10,
    S_DISCHARGE = 6'h20
  } sup_state_t;

  typedef struct packed {
    logic [VW-1:0]    dump_threshold;
    logic [PWM_W-1:0] dump_duty;
    logic [DUR_W-1:0] dump_duration;
    logic [VW-1:0]    precharge_threshold;
  } bus_cfg_t;

  typedef struct packed {
    logic [VW-1:0] overcurrent;
    logic [VW-1:0] overvoltage;
  } limits_t;

  typedef struct packed {
    logic overcurrent;
    logic overvoltage;
    logic external;
  } faults_t;

  typedef struct packed {
    logic [GPIO_N-1:0]       dir;
    logic [GPIO_N-1:0][1:0]  event_sel;
  } gpio_cfg_t;

endpackage

/* File: logic/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] pin_s
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  always_comb begin
    st_d        = st_q;
    st_d.meta   = pin_i;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_s = st_q.stable;

endmodule

/* File: logic/drive_supervisor.sv */
// How it works
// - The drive stays off until an enable command arrives in the ready state while no fault is active.
// - Once a fault has stopped the drive, enable is ignored until faults are gone and reset is sent.
// - The holding brake output is high while the brake is engaged and low to release it.
// - The bus dump output is raised when the bus voltage exceeds the programmed dump threshold.
// - While dumping, the output is pulsed at the programmed duty for the programmed duration.
// - The precharge output stays on at power-up until the bus reaches the precharge threshold.
// - During power-down the discharge output is raised to drain the bus capacitors.
// - Each general pin is set as input or output and maps to one selectable system event.
// - With encoder feedback deselected the six encoder lines serve as extra digital inputs.
// - With Hall feedback deselected the three Hall lines serve as digital inputs.
// - The analog input may be chosen as command source in current, velocity or position mode.
// - A phase current above the over-current limit stops the drive and latches a fault.
// - After logic power-up the stored limits are loaded into the active limits.
`timescale 1ns/1ps
module drive_supervisor
  import drive_sup_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = DUMP_TICK_CYCLES_DEF
) (
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  input  wire logic                         host_enable_cmd,
  input  wire logic                         host_disable_cmd,
  input  wire logic                         host_reset_cmd,
  input  wire logic                         external_fault,
  input  wire bus_cfg_t                     bus_cfg,
  input  wire limits_t                      stored_limits,
  input  wire logic [VW-1:0]                dc_link_voltage,
  input  wire logic [PHASE_N-1:0][VW-1:0]   phase_current,
  input  wire logic                         power_down_pin,
  input  wire gpio_cfg_t                    gpio_cfg,
  input  wire logic [GPIO_N-1:0]            gpio_pin_i,
  input  wire logic                         encoder_feedback_sel,
  input  wire logic [ENC_N-1:0]             encoder_pin_i,
  input  wire logic                         hall_feedback_sel,
  input  wire logic [HALL_N-1:0]            hall_pin_i,
  input  wire logic                         analog_cmd_select,
  input  wire cmd_mode_t                    cmd_mode_sel,
  input  wire logic [CW-1:0]                analog_cmd,
  input  wire logic [CW-1:0]                host_cmd,
  output logic                              drive_enable,
  output logic                              holding_brake_output,
  output logic                              bus_dump_command,
  output logic                              precharge_command,
  output logic                              discharge_command,
  output faults_t                           fault_status,
  output sup_state_t                        sup_state,
  output limits_t                           limits_active,
  output logic [GPIO_N-1:0]                 gpio_pin_o,
  output logic [GPIO_N-1:0]                 gpio_pin_oe,
  output logic [GPIO_N-1:0]                 gpio_in,
  output logic [ENC_N-1:0]                  aux_encoder_in,
  output logic [HALL_N-1:0]                 aux_hall_in,
  output logic [CW-1:0]                     cmd_value,
  output cmd_mode_t                         cmd_mode
);

  typedef struct packed {
    sup_state_t          state;
    faults_t             faults;
    limits_t             limits;
    logic                drive_en;
    logic                brake;
    logic                precharge;
    logic                discharge;
    logic                dump_active;
    logic                dump_spent;
    logic                dump_out;
    logic [PWM_W-1:0]    pwm_cnt;
    logic [DUR_W-1:0]    dur_cnt;
    logic [TICK_W-1:0]   tick_cnt;
    logic [GPIO_N-1:0]   gpio_o;
    logic [GPIO_N-1:0]   gpio_oe;
    logic [GPIO_N-1:0]   gpio_in;
    logic [ENC_N-1:0]    aux_enc;
    logic [HALL_N-1:0]   aux_hall;
    logic [CW-1:0]       cmd_value;
    cmd_mode_t           cmd_mode;
  } sup_reg_t;

  // brake engaged and precharge on from the first cycle
  localparam sup_reg_t ST_INIT = '{state: S_LOAD, brake: 1'b1, precharge: 1'b1,
                                   cmd_mode: CMD_CURRENT, default: '0};
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  sup_reg_t st_q;
  sup_reg_t st_d;

  logic [PIN_N-1:0]  pins_s;
  logic [GPIO_N-1:0] gpio_s;
  logic [ENC_N-1:0]  enc_s;
  logic [HALL_N-1:0] hall_s;
  logic              power_down_s;
  logic              oc_now;
  logic              ov_now;
  logic              cond_any;
  logic              fault_any;
  logic              dump_over;
  logic              tick;
  logic [3:0]        events;

  pin_sync #(.W(PIN_N)) u_pin_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_i    ({gpio_pin_i, encoder_pin_i, hall_pin_i, power_down_pin}),
    .pin_s    (pins_s)
  );

  assign {gpio_s, enc_s, hall_s, power_down_s} = pins_s;

  always_comb begin
    st_d   = st_q;
    oc_now = 1'b0;
    for (int i = 0; i < PHASE_N; i++) begin
      if (phase_current[i] > st_q.limits.overcurrent) begin
        oc_now = 1'b1;
      end
    end
    ov_now    = dc_link_voltage > st_q.limits.overvoltage;
    cond_any  = oc_now | ov_now | external_fault;
    fault_any = cond_any | (|st_q.faults);
    tick      = (st_q.tick_cnt == TICK_LAST);
    dump_over = dc_link_voltage > bus_cfg.dump_threshold;

    st_d.tick_cnt = tick ? '0 : st_q.tick_cnt + 1'b1;

    // a live condition re-sets its flag even in the clearing cycle
    st_d.faults.overcurrent = oc_now | (st_q.faults.overcurrent & ~host_reset_cmd);
    st_d.faults.overvoltage = ov_now | (st_q.faults.overvoltage & ~host_reset_cmd);
    st_d.faults.external    = external_fault | (st_q.faults.external & ~host_reset_cmd);

    case (st_q.state)
      S_LOAD: begin
        st_d.limits = stored_limits;
        st_d.state  = S_PRECHARGE;
      end
      S_PRECHARGE: begin
        if (dc_link_voltage >= bus_cfg.precharge_threshold) begin
          st_d.state = S_READY;
        end
      end
      S_READY: begin
        if (host_enable_cmd && !fault_any) begin
          st_d.state = S_ENABLED;
        end
      end
      S_ENABLED: begin
        if (fault_any) begin
          st_d.state = S_FAULTED;
        end else if (host_disable_cmd) begin
          st_d.state = S_READY;
        end
      end
      S_FAULTED: begin
        // enable ignored here; only a reset with faults gone releases
        if (host_reset_cmd && !cond_any) begin
          st_d.state = S_READY;
        end
      end
      S_DISCHARGE: begin
        if (!power_down_s) begin
          st_d.state = S_PRECHARGE;
        end
      end
      default: begin
        st_d.state = S_LOAD;
      end
    endcase

    if (power_down_s && st_q.state != S_LOAD) begin
      st_d.state = S_DISCHARGE;
    end

    st_d.drive_en  = (st_d.state == S_ENABLED);
    st_d.brake     = ~st_d.drive_en;
    st_d.precharge = (st_d.state == S_PRECHARGE);
    st_d.discharge = (st_d.state == S_DISCHARGE);

    // spent flag stops a retrigger until the bus drops back
    if (!dump_over) begin
      st_d.dump_active = 1'b0;
      st_d.dump_spent  = 1'b0;
    end else if (!st_q.dump_active && !st_q.dump_spent) begin
      st_d.dump_active = 1'b1;
      st_d.pwm_cnt     = '0;
      st_d.dur_cnt     = '0;
    end else if (st_q.dump_active) begin
      st_d.pwm_cnt = st_q.pwm_cnt + 1'b1;
      if (tick) begin
        if (st_q.dur_cnt >= bus_cfg.dump_duration) begin
          st_d.dump_active = 1'b0;
          st_d.dump_spent  = 1'b1;
        end else begin
          st_d.dur_cnt = st_q.dur_cnt + 1'b1;
        end
      end
    end
    st_d.dump_out = st_d.dump_active && (st_d.pwm_cnt < bus_cfg.dump_duty);

    events[EV_ENABLED] = st_d.drive_en;
    events[EV_FAULT]   = (st_d.state == S_FAULTED);
    events[EV_BRAKE]   = st_d.brake;
    events[EV_DUMP]    = st_d.dump_out;
    for (int i = 0; i < GPIO_N; i++) begin
      st_d.gpio_oe[i] = gpio_cfg.dir[i];
      st_d.gpio_o[i]  = gpio_cfg.dir[i] & events[gpio_cfg.event_sel[i]];
    end
    st_d.gpio_in  = gpio_s & ~gpio_cfg.dir;
    st_d.aux_enc  = encoder_feedback_sel ? '0 : enc_s;
    st_d.aux_hall = hall_feedback_sel ? '0 : hall_s;

    st_d.cmd_value = analog_cmd_select ? analog_cmd : host_cmd;
    st_d.cmd_mode  = cmd_mode_sel;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= ST_INIT;
    end else begin
      st_q <= st_d;
    end
  end

  assign drive_enable         = st_q.drive_en;
  assign holding_brake_output = st_q.brake;
  assign bus_dump_command     = st_q.dump_out;
  assign precharge_command    = st_q.precharge;
  assign discharge_command    = st_q.discharge;
  assign fault_status         = st_q.faults;
  assign sup_state            = st_q.state;
  assign limits_active        = st_q.limits;
  assign gpio_pin_o           = st_q.gpio_o;
  assign gpio_pin_oe          = st_q.gpio_oe;
  assign gpio_in              = st_q.gpio_in;
  assign aux_encoder_in       = st_q.aux_enc;
  assign aux_hall_in          = st_q.aux_hall;
  assign cmd_value            = st_q.cmd_value;
  assign cmd_mode             = st_q.cmd_mode;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_ENABLE_NEEDS_CMD: assert property (
    $rose(drive_enable) |-> $past(host_enable_cmd) && $past(st_q.state) == S_READY
  ) else $error("drive enabled without an enable command in ready");

  AST_ENABLE_NO_FAULT: assert property (
    $rose(drive_enable) |-> !$past(external_fault) && $past(fault_status) == '0
  ) else $error("drive enabled while a fault was active");

  AST_FAULT_HOLDS_OFF: assert property (
    (st_q.state == S_FAULTED && !host_reset_cmd) |=> !drive_enable [*2]
  ) else $error("enable accepted in faulted state without reset");

  AST_BRAKE_POLARITY: assert property (
    holding_brake_output == (sup_state != S_ENABLED)
  ) else $error("brake not engaged while drive is off");

  AST_DUMP_START: assert property (
    (dump_over && !st_q.dump_active && !st_q.dump_spent) |=> st_q.dump_active
  ) else $error("dump did not start above threshold");

  AST_DUMP_GATED: assert property (
    bus_dump_command |-> st_q.dump_active && st_q.pwm_cnt < bus_cfg.dump_duty
  ) else $error("dump pulse outside its duty window");

  AST_DUMP_STOP: assert property (
    !dump_over |=> !bus_dump_command && !st_q.dump_active
  ) else $error("dump still on below threshold");

  AST_PRECHARGE_RELEASE: assert property (
    (st_q.state == S_PRECHARGE && dc_link_voltage >= bus_cfg.precharge_threshold
      && !power_down_s) |=> !precharge_command && sup_state == S_READY
  ) else $error("precharge not released at threshold");

  AST_DISCHARGE_ON: assert property (
    (power_down_s && st_q.state != S_LOAD) |=> discharge_command && !drive_enable
  ) else $error("discharge not raised at power-down");

  AST_OVERCURRENT_TRIP: assert property (
    (drive_enable && oc_now) |=> !drive_enable && fault_status.overcurrent
  ) else $error("over-current did not stop the drive");

  AST_LIMITS_LOADED: assert property (
    st_q.state == S_LOAD |=> limits_active == $past(stored_limits)
  ) else $error("stored limits not loaded after power-up");

  AST_AUX_ENCODER: assert property (
    encoder_feedback_sel |=> aux_encoder_in == '0
  ) else $error("encoder lines leak while feedback selected");

endmodule

/* File: testbench/bus_circuit_model.sv */
`timescale 1ns/1ps
module bus_circuit_model
  import drive_sup_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic          precharge_command,
  input  wire logic          discharge_command,
  input  wire logic          holding_brake_output,
  input  wire logic [VW-1:0] supply_v,
  output logic      [VW-1:0] dc_link_voltage,
  output logic               brake_engaged
);
  // high opens the switch: coil dead, brake held
  assign brake_engaged = holding_brake_output;
  // dump load not modelled; the bench steers the supply level instead
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dc_link_voltage <= 12'h000;
    end else if (discharge_command) begin
      dc_link_voltage <= (dc_link_voltage > 12'h008) ? dc_link_voltage - 12'h008 : 12'h000;
    end else if (precharge_command && dc_link_voltage < supply_v) begin
      dc_link_voltage <= dc_link_voltage + 12'h001;
    end else begin
      dc_link_voltage <= supply_v;
    end
  end
endmodule

/* File: testbench/drive_supervisor_tb.sv */
`timescale 1ns/1ps
module drive_supervisor_tb
  import drive_sup_pkg::*;
;
  logic                       core_clk = 1'b0;
  logic                       reset, host_enable_cmd, host_disable_cmd, host_reset_cmd;
  logic                       external_fault, power_down_pin, encoder_feedback_sel;
  logic                       hall_feedback_sel, analog_cmd_select, brake_engaged;
  logic                       drive_enable, holding_brake_output, bus_dump_command;
  logic                       precharge_command, discharge_command;
  bus_cfg_t                   bus_cfg;
  limits_t                    stored_limits, limits_active;
  logic [VW-1:0]              supply_v, dc_link_voltage;
  logic [PHASE_N-1:0][VW-1:0] phase_current;
  gpio_cfg_t                  gpio_cfg;
  logic [GPIO_N-1:0]          gpio_pin_i, gpio_pin_o, gpio_pin_oe, gpio_in;
  logic [ENC_N-1:0]           encoder_pin_i, aux_encoder_in;
  logic [HALL_N-1:0]          hall_pin_i, aux_hall_in;
  cmd_mode_t                  cmd_mode_sel, cmd_mode;
  logic [CW-1:0]              analog_cmd, host_cmd, cmd_value;
  faults_t                    fault_status;
  sup_state_t                 sup_state;
  int                         bad_count = 0;
  int                         n_tests = 0;
  int                         i, c;

  always #12.5 core_clk = ~core_clk;

  drive_supervisor #(.TICK_CYCLES(4)) drive_supervisor_inst (
    .core_clk, .reset, .host_enable_cmd, .host_disable_cmd, .host_reset_cmd,
    .external_fault, .bus_cfg, .stored_limits, .dc_link_voltage, .phase_current,
    .power_down_pin, .gpio_cfg, .gpio_pin_i, .encoder_feedback_sel, .encoder_pin_i,
    .hall_feedback_sel, .hall_pin_i, .analog_cmd_select, .cmd_mode_sel, .analog_cmd,
    .host_cmd, .drive_enable, .holding_brake_output, .bus_dump_command,
    .precharge_command, .discharge_command, .fault_status, .sup_state, .limits_active,
    .gpio_pin_o, .gpio_pin_oe, .gpio_in, .aux_encoder_in, .aux_hall_in, .cmd_value,
    .cmd_mode
  );

  bus_circuit_model bus_circuit_model_inst (
    .core_clk, .reset, .precharge_command, .discharge_command,
    .holding_brake_output, .supply_v, .dc_link_voltage, .brake_engaged
  );

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic guard(int k, int lim);
    if (k >= lim) begin
      bad_count++;
      $display("mismatch wait expected %0d seen %0d", lim - 1, k);
      end_of_test();
    end
  endtask

  task automatic pulse(logic [2:0] v);
    {host_enable_cmd, host_disable_cmd, host_reset_cmd} = v;
    step(1);
    {host_enable_cmd, host_disable_cmd, host_reset_cmd} = 3'h0;
    // idle edge so back-to-back calls never rewrite a strobe in one step
    step(1);
  endtask

  task automatic count_dump(int n);
    c = 0;
    repeat (n) begin
      c += (bus_dump_command === 1'b1);
      step(1);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    {host_enable_cmd, host_disable_cmd, host_reset_cmd} = 3'h0;
    {external_fault, power_down_pin, analog_cmd_select} = 3'h0;
    {encoder_feedback_sel, hall_feedback_sel} = 2'h3;
    bus_cfg = '{12'h300, 8'h02, 16'hFFFF, 12'h100};
    stored_limits = '{12'h800, 12'hF00};
    supply_v = 12'h200;
    phase_current = '0;
    gpio_cfg = '{4'hB, {EV_DUMP, EV_FAULT, EV_BRAKE, EV_ENABLED}};
    gpio_pin_i = 4'hF;
    encoder_pin_i = 6'h2A;
    hall_pin_i = 3'h5;
    analog_cmd = 16'h1234;
    host_cmd = 16'hABCD;
    cmd_mode_sel = CMD_CURRENT;
    step(4);
    chk("brake", 1, holding_brake_output);
    chk("drive", 0, drive_enable);
    chk("aux_enc", 0, aux_encoder_in);
    chk("aux_hall", 0, aux_hall_in);
    reset = 1'b0;
    step(1);
    chk("limits", stored_limits, limits_active);
    pulse(3'h4);
    chk("drive", 0, drive_enable);
    for (i = 0; i < 600 && dc_link_voltage < 12'h100; i++) step(1);
    guard(i, 600);
    chk("precharge", 1, precharge_command);
    step(1);
    chk("precharge", 0, precharge_command);
    chk("state", S_READY, sup_state);
    chk("brake_ext", 1, brake_engaged);
    pulse(3'h4);
    chk("drive", 1, drive_enable);
    chk("brake", 0, holding_brake_output);
    chk("gpio_o", 4'h1, gpio_pin_o);
    chk("gpio_oe", 4'hB, gpio_pin_oe);
    chk("gpio_in", 4'h4, gpio_in);
    phase_current[1] = 12'h800;
    step(2);
    chk("drive", 1, drive_enable);
    phase_current[1] = 12'h801;
    step(1);
    chk("drive", 0, drive_enable);
    chk("faults", 3'h4, fault_status);
    chk("gpio_o", 4'h2, gpio_pin_o);
    pulse(3'h4);
    pulse(3'h1);
    chk("state", S_FAULTED, sup_state);
    phase_current = '0;
    pulse(3'h4);
    chk("drive", 0, drive_enable);
    pulse(3'h1);
    chk("state", S_READY, sup_state);
    chk("faults", 3'h0, fault_status);
    pulse(3'h4);
    chk("drive", 1, drive_enable);
    external_fault = 1'b1;
    step(1);
    chk("faults", 3'h1, fault_status);
    external_fault = 1'b0;
    pulse(3'h1);
    chk("state", S_READY, sup_state);
    {encoder_feedback_sel, hall_feedback_sel} = 2'h0;
    step(4);
    chk("aux_enc", 6'h2A, aux_encoder_in);
    chk("aux_hall", 3'h5, aux_hall_in);
    {encoder_feedback_sel, hall_feedback_sel} = 2'h3;
    step(1);
    chk("aux_enc", 0, aux_encoder_in);
    chk("aux_hall", 0, aux_hall_in);
    for (i = 0; i < 3; i++) begin
      cmd_mode_sel = cmd_mode_t'(i);
      analog_cmd_select = (i != 1);
      step(1);
      chk("mode", i, cmd_mode);
      chk("cmd", (i != 1) ? 16'h1234 : 16'hABCD, cmd_value);
    end
    supply_v = 12'h400;
    for (i = 0; i < 10 && bus_dump_command !== 1'b1; i++) step(1);
    guard(i, 10);
    chk("gpio_o", 4'hA, gpio_pin_o);
    count_dump(256);
    chk("dump_duty", 2, c);
    supply_v = 12'h300;
    for (i = 0; i < 10 && dc_link_voltage !== 12'h300; i++) step(1);
    guard(i, 10);
    step(1);
    chk("dump", 0, bus_dump_command);
    // a whole pwm period, so a dump left running would show its duty
    count_dump(256);
    chk("dump_off", 0, c);
    bus_cfg.dump_duty = 8'hFF;
    bus_cfg.dump_duration = 16'h0003;
    supply_v = 12'h400;
    count_dump(40);
    // three or four 4-cycle ticks, plus trigger latency
    chk("dump_span", 1, c >= 10 && c <= 18);
    count_dump(40);
    chk("dump_spent", 0, c);
    power_down_pin = 1'b1;
    step(2);
    chk("discharge", 0, discharge_command);
    step(1);
    chk("discharge", 1, discharge_command);
    for (i = 0; i < 200 && dc_link_voltage !== 12'h000; i++) step(1);
    guard(i, 200);
    power_down_pin = 1'b0;
    step(3);
    chk("discharge", 0, discharge_command);
    chk("precharge", 1, precharge_command);
    end_of_test();
  end
endmodule
